/* File: shared/modem_regs_pkg.sv */
package modem_regs_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CARRIER_RETURN = 8'h37;
  localparam logic [7:0] IDX_CARRIER_WAIT = 8'h39;
  localparam logic [7:0] IDX_ANSWER_DELAY = 8'h3A;
  localparam logic [7:0] IDX_RING_PULSES = 8'h3B;
  localparam logic [7:0] IDX_CALLER_ID_GAIN = 8'h3C;
  localparam logic [7:0] IDX_RESULT_CODE = 8'h62;
  localparam logic [7:0] IDX_INTRUSION = 8'h82;
  localparam logic [7:0] IDX_LINE_VOLTAGE = 8'hDB;
  localparam logic [7:0] IDX_DIGITAL_GAIN = 8'hDF;
  localparam logic [7:0] IDX_CONFIG_ONE = 8'hE0;
  localparam logic [7:0] IDX_PIN_CFG_A = 8'hE1;
  localparam logic [7:0] IDX_PIN_CFG_B = 8'hE2;
  localparam logic [7:0] IDX_PIN_DIR = 8'hE3;
  localparam logic [7:0] IDX_CONFIG_FIVE = 8'hE4;
  localparam logic [7:0] IDX_WINDOW_LOW = 8'hE5;
  localparam logic [7:0] IDX_WINDOW_HIGH = 8'hE6;
  localparam logic [7:0] IDX_WINDOW_SELECT = 8'hE8;

  // Reset values
  localparam logic [7:0] RST_CARRIER_RETURN = 8'h20;
  localparam logic [7:0] RST_CARRIER_WAIT = 8'h3C;
  localparam logic [7:0] RST_ANSWER_DELAY = 8'h29;
  localparam logic [7:0] RST_RING_PULSES = 8'h03;
  localparam logic [7:0] RST_CALLER_ID_GAIN = 8'h01;
  localparam logic [7:0] RST_RESULT_CODE = 8'h41;
  localparam logic [7:0] RST_INTRUSION = 8'h08;
  localparam logic [7:0] RST_DIGITAL_GAIN = 8'h0C;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h22;
  localparam logic [7:0] RST_PIN_CFG_A = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Window modes
  localparam logic [7:0] WIN_MODE_ADDR = 8'h00;
  localparam logic [7:0] WIN_MODE_DATA = 8'h01;
  localparam logic [7:0] WIN_MODE_BITS = 8'h02;
  localparam int DSP_DATA_HI_W = 6;

  // Timing: 40 MHz clock
  localparam int CLK_MHZ = 40;
  localparam int RETURN_UNIT_NUM_US = 5000;
  localparam int RETURN_UNIT_DEN = 3;
  localparam int WAIT_UNIT_US = 1000000;
  localparam int TONE_UNIT_US = 53330;
  localparam int RETURN_UNIT_CYC =
    (RETURN_UNIT_NUM_US * CLK_MHZ + RETURN_UNIT_DEN - 1) / RETURN_UNIT_DEN;
  localparam int WAIT_UNIT_CYC = WAIT_UNIT_US * CLK_MHZ;
  localparam int TONE_UNIT_CYC = TONE_UNIT_US * CLK_MHZ;
  localparam logic [7:0] LINE_MIN_VOLTS = 8'h03;

  // DSP window contents and write strobes
  typedef struct packed {
    logic [15:0] addr;
    logic [13:0] data;
    logic [7:0] ctrl_lo;
    logic [7:0] ctrl_hi;
  } dsp_window_t;

  typedef struct packed {
    logic addr_wr;
    logic data_wr;
    logic ctrl_lo_wr;
    logic ctrl_hi_wr;
  } dsp_strobe_t;
endpackage

/* File: logic/modem_timing_regs.sv */
// What this block does
// - Carrier present after continuous return-time detection
// - Abort call when carrier-wait seconds expire
// - Answer tone after delay units off-hook
// - Ring burst qualified at programmed pulse count
// - Line voltage read as signed volts
// - Line voltage under three volts in magnitude reads zero
// - Window select register steers both windows
// - Mode zero windows write DSP address
// - Mode one windows write 14-bit data
// - Mode two low window reads status, writes control
// - Mode two high window writes control
module modem_timing_regs #(
  parameter int RETURN_CYC = modem_regs_pkg::RETURN_UNIT_CYC,
  parameter int WAIT_CYC = modem_regs_pkg::WAIT_UNIT_CYC,
  parameter int TONE_CYC = modem_regs_pkg::TONE_UNIT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [modem_regs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [modem_regs_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Line events
  input wire logic carrier_det,
  input wire logic call_wait,
  input wire logic answer_mode,
  input wire logic off_hook,
  input wire logic ring_pulse,
  input wire logic ring_burst_end,
  input wire logic [7:0] line_volt,
  // Line decisions
  output logic carrier_present,
  output logic call_abort,
  output logic answer_tone_on,
  output logic ring_qualified,
  // DSP side
  input wire logic [7:0] dsp_status,
  output modem_regs_pkg::dsp_window_t dsp_win,
  output modem_regs_pkg::dsp_strobe_t dsp_wr
);

  // True on the last cycle of one time unit
  function automatic logic unit_end(input logic [31:0] pre, input int cyc);
    return pre == 32'(cyc - 1);
  endfunction

  // Register index from a byte address, plus range check
  function automatic logic [7:0] reg_idx(input logic [modem_regs_pkg::ADDR_W-1:0] a);
    return a[modem_regs_pkg::IDX_LSB +: modem_regs_pkg::IDX_W];
  endfunction

  function automatic logic in_range(input logic [modem_regs_pkg::ADDR_W-1:0] a);
    return a[modem_regs_pkg::ADDR_W-1:modem_regs_pkg::IDX_LSB+modem_regs_pkg::IDX_W] == '0;
  endfunction

  logic [7:0] carrier_return_time_ff, carrier_wait_timeout_ff, answer_tone_delay_ff;
  logic [7:0] ring_pulse_count_ff, caller_id_gain_ff, result_code_control_ff;
  logic [7:0] intrusion_settings_ff, line_voltage_status_ff, digital_gain_setting_ff;
  logic [7:0] config_one_ff, pin_config_a_ff, pin_config_b_ff, pin_direction_ff;
  logic [7:0] config_five_ff, window_mode_reg_ff;
  logic [modem_regs_pkg::ADDR_W-1:0] awaddr_ff, araddr_now;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic do_write, wr_mapped, wr_en, rd_mapped;
  logic [7:0] wr_idx, rd_idx, wr_byte, rd_val;
  logic [31:0] ret_pre_ff, wait_pre_ff, tone_pre_ff;
  logic [7:0] ret_units_ff, wait_units_ff, tone_units_ff, ring_cnt_ff;
  logic carrier_present_ff, call_abort_ff, answer_tone_ff, ring_qualified_ff;
  logic [7:0] volt_mag;
  modem_regs_pkg::dsp_window_t dsp_win_ff;
  modem_regs_pkg::dsp_strobe_t dsp_wr_ff;

  // Handshake outputs; one write and one read held at a time
  assign awready = !aw_held_ff;
  assign wready = !w_held_ff;
  assign arready = !rvalid_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign carrier_present = carrier_present_ff;
  assign call_abort = call_abort_ff;
  assign answer_tone_on = answer_tone_ff;
  assign ring_qualified = ring_qualified_ff;
  assign dsp_win = dsp_win_ff;
  assign dsp_wr = dsp_wr_ff;

  // Write commit waits for a free response slot
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_idx = reg_idx(awaddr_ff);
  assign wr_byte = wdata_ff[7:0];
  assign wr_en = do_write && wr_mapped && wstrb_ff[0];
  assign araddr_now = araddr;
  assign rd_idx = reg_idx(araddr_now);

  // Address decode for the write direction only; reads decode in the mux below
  always_comb begin
    wr_mapped = in_range(awaddr_ff);
    case (wr_idx)
      modem_regs_pkg::IDX_CARRIER_RETURN, modem_regs_pkg::IDX_CARRIER_WAIT,
      modem_regs_pkg::IDX_ANSWER_DELAY, modem_regs_pkg::IDX_RING_PULSES,
      modem_regs_pkg::IDX_CALLER_ID_GAIN, modem_regs_pkg::IDX_RESULT_CODE,
      modem_regs_pkg::IDX_INTRUSION, modem_regs_pkg::IDX_LINE_VOLTAGE,
      modem_regs_pkg::IDX_DIGITAL_GAIN, modem_regs_pkg::IDX_CONFIG_ONE,
      modem_regs_pkg::IDX_PIN_CFG_A, modem_regs_pkg::IDX_PIN_CFG_B,
      modem_regs_pkg::IDX_PIN_DIR, modem_regs_pkg::IDX_CONFIG_FIVE,
      modem_regs_pkg::IDX_WINDOW_LOW, modem_regs_pkg::IDX_WINDOW_HIGH,
      modem_regs_pkg::IDX_WINDOW_SELECT: ;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Read mux; write-only windows read zero
  always_comb begin
    rd_mapped = in_range(araddr_now);
    rd_val = 8'h00;
    case (rd_idx)
      modem_regs_pkg::IDX_CARRIER_RETURN: rd_val = carrier_return_time_ff;
      modem_regs_pkg::IDX_CARRIER_WAIT: rd_val = carrier_wait_timeout_ff;
      modem_regs_pkg::IDX_ANSWER_DELAY: rd_val = answer_tone_delay_ff;
      modem_regs_pkg::IDX_RING_PULSES: rd_val = ring_pulse_count_ff;
      modem_regs_pkg::IDX_CALLER_ID_GAIN: rd_val = caller_id_gain_ff;
      modem_regs_pkg::IDX_RESULT_CODE: rd_val = result_code_control_ff;
      modem_regs_pkg::IDX_INTRUSION: rd_val = intrusion_settings_ff;
      modem_regs_pkg::IDX_LINE_VOLTAGE: rd_val = line_voltage_status_ff;
      modem_regs_pkg::IDX_DIGITAL_GAIN: rd_val = digital_gain_setting_ff;
      modem_regs_pkg::IDX_CONFIG_ONE: rd_val = config_one_ff;
      modem_regs_pkg::IDX_PIN_CFG_A: rd_val = pin_config_a_ff;
      modem_regs_pkg::IDX_PIN_CFG_B: rd_val = pin_config_b_ff;
      modem_regs_pkg::IDX_PIN_DIR: rd_val = pin_direction_ff;
      modem_regs_pkg::IDX_CONFIG_FIVE: rd_val = config_five_ff;
      modem_regs_pkg::IDX_WINDOW_LOW: begin
        if (window_mode_reg_ff == modem_regs_pkg::WIN_MODE_BITS) begin
          rd_val = dsp_status;
        end
      end
      modem_regs_pkg::IDX_WINDOW_HIGH: rd_val = 8'h00;
      modem_regs_pkg::IDX_WINDOW_SELECT: rd_val = window_mode_reg_ff;
      default: rd_mapped = 1'b0;
    endcase
  end

  // Address and data channels are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= modem_regs_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? modem_regs_pkg::RESP_OKAY : modem_regs_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= modem_regs_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_mapped ? modem_regs_pkg::RESP_OKAY : modem_regs_pkg::RESP_SLVERR;
      rdata_ff <= {24'h00_0000, rd_val};
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Plain read/write configuration bytes; only byte lane 0 is wired
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_return_time_ff <= modem_regs_pkg::RST_CARRIER_RETURN;
      carrier_wait_timeout_ff <= modem_regs_pkg::RST_CARRIER_WAIT;
      answer_tone_delay_ff <= modem_regs_pkg::RST_ANSWER_DELAY;
      ring_pulse_count_ff <= modem_regs_pkg::RST_RING_PULSES;
      caller_id_gain_ff <= modem_regs_pkg::RST_CALLER_ID_GAIN;
      result_code_control_ff <= modem_regs_pkg::RST_RESULT_CODE;
      intrusion_settings_ff <= modem_regs_pkg::RST_INTRUSION;
      digital_gain_setting_ff <= modem_regs_pkg::RST_DIGITAL_GAIN;
      config_one_ff <= modem_regs_pkg::RST_CONFIG_ONE;
      pin_config_a_ff <= modem_regs_pkg::RST_PIN_CFG_A;
      pin_config_b_ff <= modem_regs_pkg::RST_ZERO;
      pin_direction_ff <= modem_regs_pkg::RST_ZERO;
      config_five_ff <= modem_regs_pkg::RST_ZERO;
      window_mode_reg_ff <= modem_regs_pkg::RST_ZERO;
    end else if (wr_en) begin
      case (wr_idx)
        modem_regs_pkg::IDX_CARRIER_RETURN: carrier_return_time_ff <= wr_byte;
        modem_regs_pkg::IDX_CARRIER_WAIT: carrier_wait_timeout_ff <= wr_byte;
        modem_regs_pkg::IDX_ANSWER_DELAY: answer_tone_delay_ff <= wr_byte;
        modem_regs_pkg::IDX_RING_PULSES: ring_pulse_count_ff <= wr_byte;
        modem_regs_pkg::IDX_CALLER_ID_GAIN: caller_id_gain_ff <= wr_byte;
        modem_regs_pkg::IDX_RESULT_CODE: result_code_control_ff <= wr_byte;
        modem_regs_pkg::IDX_INTRUSION: intrusion_settings_ff <= wr_byte;
        modem_regs_pkg::IDX_DIGITAL_GAIN: digital_gain_setting_ff <= wr_byte;
        modem_regs_pkg::IDX_CONFIG_ONE: config_one_ff <= wr_byte;
        modem_regs_pkg::IDX_PIN_CFG_A: pin_config_a_ff <= wr_byte;
        modem_regs_pkg::IDX_PIN_CFG_B: pin_config_b_ff <= wr_byte;
        modem_regs_pkg::IDX_PIN_DIR: pin_direction_ff <= wr_byte;
        modem_regs_pkg::IDX_CONFIG_FIVE: config_five_ff <= wr_byte;
        modem_regs_pkg::IDX_WINDOW_SELECT: window_mode_reg_ff <= wr_byte;
        default: ;
      endcase
    end
  end

  // DSP window: meaning of both bytes follows the select register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsp_win_ff <= '0;
      dsp_wr_ff <= '0;
    end else begin
      dsp_wr_ff <= '0;
      if (wr_en && wr_idx == modem_regs_pkg::IDX_WINDOW_LOW) begin
        case (window_mode_reg_ff)
          modem_regs_pkg::WIN_MODE_ADDR: begin
            dsp_win_ff.addr[7:0] <= wr_byte;
            dsp_wr_ff.addr_wr <= 1'b1;
          end
          modem_regs_pkg::WIN_MODE_DATA: begin
            dsp_win_ff.data[7:0] <= wr_byte;
            dsp_wr_ff.data_wr <= 1'b1;
          end
          modem_regs_pkg::WIN_MODE_BITS: begin
            dsp_win_ff.ctrl_lo <= wr_byte;
            dsp_wr_ff.ctrl_lo_wr <= 1'b1;
          end
          default: ;
        endcase
      end
      if (wr_en && wr_idx == modem_regs_pkg::IDX_WINDOW_HIGH) begin
        case (window_mode_reg_ff)
          modem_regs_pkg::WIN_MODE_ADDR: begin
            dsp_win_ff.addr[15:8] <= wr_byte;
            dsp_wr_ff.addr_wr <= 1'b1;
          end
          modem_regs_pkg::WIN_MODE_DATA: begin
            dsp_win_ff.data[13:8] <= wr_byte[modem_regs_pkg::DSP_DATA_HI_W-1:0];
            dsp_wr_ff.data_wr <= 1'b1;
          end
          modem_regs_pkg::WIN_MODE_BITS: begin
            dsp_win_ff.ctrl_hi <= wr_byte;
            dsp_wr_ff.ctrl_hi_wr <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Line voltage magnitude; -128 maps to 0x80, still above the floor
  assign volt_mag = line_volt[7] ? 8'(-line_volt) : line_volt;

  // Sampled every cycle so software always sees the latest reading
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_voltage_status_ff <= 8'h00;
    end else if (volt_mag < modem_regs_pkg::LINE_MIN_VOLTS) begin
      line_voltage_status_ff <= 8'h00;
    end else begin
      line_voltage_status_ff <= line_volt;
    end
  end

  // Carrier return qualification; any dropout restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn || !carrier_det) begin
      ret_pre_ff <= 32'h0000_0000;
      ret_units_ff <= 8'h00;
      carrier_present_ff <= 1'b0;
    end else if (!carrier_present_ff) begin
      if (ret_units_ff >= carrier_return_time_ff) begin
        carrier_present_ff <= 1'b1;
      end else if (unit_end(ret_pre_ff, RETURN_CYC)) begin
        ret_pre_ff <= 32'h0000_0000;
        ret_units_ff <= 8'(ret_units_ff + 8'h01);
      end else begin
        ret_pre_ff <= 32'(ret_pre_ff + 32'h0000_0001);
      end
    end
  end

  // Carrier wait timeout; abort holds until the call attempt drops or carrier is present
  always_ff @(posedge aclk) begin
    if (!aresetn || !call_wait || carrier_present_ff) begin
      wait_pre_ff <= 32'h0000_0000;
      wait_units_ff <= 8'h00;
      call_abort_ff <= 1'b0;
    end else if (!call_abort_ff) begin
      if (wait_units_ff >= carrier_wait_timeout_ff) begin
        call_abort_ff <= 1'b1;
      end else if (unit_end(wait_pre_ff, WAIT_CYC)) begin
        wait_pre_ff <= 32'h0000_0000;
        wait_units_ff <= 8'(wait_units_ff + 8'h01);
      end else begin
        wait_pre_ff <= 32'(wait_pre_ff + 32'h0000_0001);
      end
    end
  end

  // Answer tone delay from off-hook in answer mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !(answer_mode && off_hook)) begin
      tone_pre_ff <= 32'h0000_0000;
      tone_units_ff <= 8'h00;
      answer_tone_ff <= 1'b0;
    end else if (!answer_tone_ff) begin
      if (tone_units_ff >= answer_tone_delay_ff) begin
        answer_tone_ff <= 1'b1;
      end else if (unit_end(tone_pre_ff, TONE_CYC)) begin
        tone_pre_ff <= 32'h0000_0000;
        tone_units_ff <= 8'(tone_units_ff + 8'h01);
      end else begin
        tone_pre_ff <= 32'(tone_pre_ff + 32'h0000_0001);
      end
    end
  end

  // Ring pulse count per burst; saturates so long bursts stay qualified
  always_ff @(posedge aclk) begin
    if (!aresetn || ring_burst_end) begin
      ring_cnt_ff <= 8'h00;
      ring_qualified_ff <= 1'b0;
    end else if (ring_pulse) begin
      if (ring_cnt_ff != 8'hFF) begin
        ring_cnt_ff <= 8'(ring_cnt_ff + 8'h01);
      end
      if (8'(ring_cnt_ff + 8'h01) >= ring_pulse_count_ff) begin
        ring_qualified_ff <= 1'b1;
      end
    end
  end

  // Run-length helpers watched only by the checks below
  logic [39:0] det_run_ff, wait_run_ff, tone_run_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_run_ff <= '0;
      wait_run_ff <= '0;
      tone_run_ff <= '0;
    end else begin
      det_run_ff <= carrier_det ? 40'(det_run_ff + 40'h1) : '0;
      wait_run_ff <= (call_wait && !carrier_present_ff) ? 40'(wait_run_ff + 40'h1) : '0;
      tone_run_ff <= (answer_mode && off_hook) ? 40'(tone_run_ff + 40'h1) : '0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_return_qualify: assert property (
    $rose(carrier_present) |->
      det_run_ff >= 40'(carrier_return_time_ff) * 40'(RETURN_CYC) && $past(carrier_det))
    else $error("carrier accepted before return time");
  a_wait_abort: assert property (
    $rose(call_abort) |->
      wait_run_ff >= 40'(carrier_wait_timeout_ff) * 40'(WAIT_CYC) && !$past(carrier_present))
    else $error("call aborted before carrier wait elapsed");
  a_tone_delay: assert property (
    $rose(answer_tone_on) |->
      tone_run_ff >= 40'(answer_tone_delay_ff) * 40'(TONE_CYC))
    else $error("answer tone started early");
  a_ring_count: assert property (
    $rose(ring_qualified) |-> ring_cnt_ff >= ring_pulse_count_ff && $past(ring_pulse))
    else $error("ring burst qualified with too few pulses");
  a_volt_pass: assert property (
    volt_mag >= modem_regs_pkg::LINE_MIN_VOLTS |=>
      line_voltage_status_ff == $past(line_volt))
    else $error("line voltage not reported");
  a_volt_floor: assert property (
    volt_mag < modem_regs_pkg::LINE_MIN_VOLTS |=> line_voltage_status_ff == 8'h00)
    else $error("small line voltage not zeroed");
  a_mode_write: assert property (
    wr_en && wr_idx == modem_regs_pkg::IDX_WINDOW_SELECT |=>
      window_mode_reg_ff == $past(wr_byte))
    else $error("window select not stored");
  a_addr_window: assert property (
    wr_en && wr_idx == modem_regs_pkg::IDX_WINDOW_HIGH &&
      window_mode_reg_ff == modem_regs_pkg::WIN_MODE_ADDR |=>
      dsp_win.addr[15:8] == $past(wr_byte) && dsp_wr.addr_wr)
    else $error("dsp address high byte not written");
  a_data_window: assert property (
    wr_en && wr_idx == modem_regs_pkg::IDX_WINDOW_LOW &&
      window_mode_reg_ff == modem_regs_pkg::WIN_MODE_DATA |=>
      dsp_win.data[7:0] == $past(wr_byte) && dsp_wr.data_wr && !dsp_wr.addr_wr)
    else $error("dsp data low byte not written");
  a_status_read: assert property (
    arvalid && arready && rd_mapped && rd_idx == modem_regs_pkg::IDX_WINDOW_LOW &&
      window_mode_reg_ff == modem_regs_pkg::WIN_MODE_BITS |=>
      rvalid && rdata[7:0] == $past(dsp_status))
    else $error("dsp status not returned");
  a_ctrl_high: assert property (
    wr_en && wr_idx == modem_regs_pkg::IDX_WINDOW_HIGH &&
      window_mode_reg_ff == modem_regs_pkg::WIN_MODE_BITS |=>
      dsp_win.ctrl_hi == $past(wr_byte) && dsp_wr.ctrl_hi_wr)
    else $error("dsp control high not written");
  a_idle_mode: assert property (
    window_mode_reg_ff > modem_regs_pkg::WIN_MODE_BITS |=>
      $stable(dsp_win) && dsp_wr == '0)
    else $error("window acted in unused mode");

endmodule

/* File: bench/modem_timing_regs_bench.sv */
module modem_timing_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready;
  logic rvalid, carrier_det, call_wait, answer_mode, off_hook, ring_pulse, ring_burst_end;
  logic carrier_present, call_abort, answer_tone_on, ring_qualified;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] line_volt, dsp_status;
  modem_regs_pkg::dsp_window_t dsp_win, ew;
  modem_regs_pkg::dsp_strobe_t dsp_wr;
  int fail_count = 0;
  int num_checks = 0;
  // Short unit counts keep the timer tests fast
  modem_timing_regs #(.RETURN_CYC(10), .WAIT_CYC(50), .TONE_CYC(20)) i_modem_timing_regs (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .carrier_det, .call_wait, .answer_mode, .off_hook, .ring_pulse, .ring_burst_end, .line_volt,
    .carrier_present, .call_abort, .answer_tone_on, .ring_qualified, .dsp_status, .dsp_win,
    .dsp_wr);
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Readiness is sampled at the falling edge, where it is settled before the taking edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r,
                    output logic [3:0] s);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      s = dsp_wr;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    logic ta, tb;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = arvalid & arready;
      tb = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Step the clock n edges, then look at the settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic t_reset;
    logic [15:0] tbl[14] = '{16'h3720, 16'h393C, 16'h3A29, 16'h3B03, 16'h3C01, 16'h6241,
      16'h8208, 16'hDF0C, 16'hE022, 16'hE104, 16'hE200, 16'hE300, 16'hE400, 16'hE800};
    logic [7:0] d;
    logic [1:0] r;
    foreach (tbl[i]) begin
      rd(tbl[i][15:8], d, r);
      chk({r, d}, {2'h0, tbl[i][7:0]}, "reset value");
    end
    $display("reset values done");
  endtask
  task automatic t_window;
    logic [3:0] slo[4] = '{4'h8, 4'h4, 4'h2, 4'h0};
    logic [3:0] shi[4] = '{4'h8, 4'h4, 4'h1, 4'h0};
    logic [7:0] d, lo, hi;
    logic [1:0] r;
    logic [3:0] s;
    ew = '0;
    for (int m = 0; m < 4; m++) begin
      lo = 8'h50 + 8'(m);
      hi = 8'hA0 + 8'(m);
      wr(8'hE8, 8'(m), r, s);
      rd(8'hE8, d, r);
      chk(d, 8'(m), "window select");
      wr(8'hE5, lo, r, s);
      chk(s, slo[m], "low strobe");
      wr(8'hE6, hi, r, s);
      chk(s, shi[m], "high strobe");
      case (m)
        0: ew.addr = {hi, lo};
        1: ew.data = {hi[5:0], lo};
        2: begin
          ew.ctrl_lo = lo;
          ew.ctrl_hi = hi;
        end
        default: ;
      endcase
      chk(dsp_win, ew, "window contents");
      rd(8'hE5, d, r);
      chk(d, (m == 2) ? dsp_status : 8'h00, "low window read");
      rd(8'hE6, d, r);
      chk(d, 8'h00, "high window read");
    end
    $display("window modes done");
  endtask
  task automatic t_volt_bus;
    logic [15:0] tbl[7] = '{16'h0000, 16'h0200, 16'h0303, 16'hFE00, 16'hFDFD, 16'h8080,
      16'h7F7F};
    logic [7:0] d;
    logic [1:0] r;
    logic [3:0] s;
    foreach (tbl[i]) begin
      line_volt <= tbl[i][15:8];
      rd(8'hDB, d, r);
      chk(d, tbl[i][7:0], "line voltage");
    end
    wr(8'hDB, 8'h55, r, s);
    rd(8'hDB, d, r);
    chk({r, d}, 10'h07F, "read-only line voltage");
    wr(8'h38, 8'h11, r, s);
    chk(r, 2'h2, "unmapped write");
    rd(8'h38, d, r);
    chk({r, d}, 10'h200, "unmapped read");
    $display("line voltage and bus done");
  endtask
  task automatic t_ring_timers;
    logic [1:0] r;
    logic [3:0] s;
    wr(8'h3B, 8'h02, r, s);
    for (int p = 1; p <= 2; p++) begin
      ring_pulse <= 1'b1;
      @(posedge aclk);
      ring_pulse <= 1'b0;
      @(negedge aclk);
      chk(ring_qualified, p == 2, "ring qualify");
      // Back on a rising edge so the next pulse is driven there
      @(posedge aclk);
    end
    ring_burst_end <= 1'b1;
    step(1);
    @(posedge aclk);
    ring_burst_end <= 1'b0;
    chk(ring_qualified, 1'b0, "ring burst end");
    // Return time 2 units of 10 cycles
    wr(8'h37, 8'h02, r, s);
    carrier_det <= 1'b1;
    step(15);
    chk(carrier_present, 1'b0, "carrier early");
    step(10);
    chk(carrier_present, 1'b1, "carrier present");
    @(posedge aclk);
    carrier_det <= 1'b0;
    step(2);
    chk(carrier_present, 1'b0, "carrier lost");
    wr(8'h39, 8'h01, r, s);
    call_wait <= 1'b1;
    step(40);
    chk(call_abort, 1'b0, "abort early");
    step(15);
    chk(call_abort, 1'b1, "call abort");
    @(posedge aclk);
    call_wait <= 1'b0;
    wr(8'h3A, 8'h01, r, s);
    answer_mode <= 1'b1;
    off_hook <= 1'b1;
    step(15);
    chk(answer_tone_on, 1'b0, "tone early");
    step(10);
    chk(answer_tone_on, 1'b1, "answer tone");
    $display("ring and timers done");
  endtask
  // Cuts a hang short well beyond the expected run
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    print_verdict;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, carrier_det, call_wait} = '0;
    {answer_mode, off_hook, ring_pulse, ring_burst_end} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    line_volt = 8'h00;
    dsp_status = 8'hA5;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_window;
    t_volt_bus;
    t_ring_timers;
    print_verdict;
  end
endmodule
